/* src/ats_regs.vh */
`ifndef ATS_REGS_VH
`define ATS_REGS_VH

// framing counts, in serial-clock pulses
`define ATS_ADDR_BITS 4'h8
`define ATS_ACK_PULSE 4'h9
`define ATS_HOLD_PULSE 4'h2
// conversion
`define ATS_CONV_CYCLES 4'hA
`define ATS_SAR_MSB 4'h9
`define ATS_SAR_TRIAL 10'h200
// result framing: pad ones above the 10-bit result in a 16-bit read
`define ATS_PAD_ONES 6'h3F
// analog mux leg codes
`define ATS_LEG_AIN0 2'h0
`define ATS_LEG_AIN1 2'h1
`define ATS_LEG_GND 2'h2
// default slave address of the framing logic
`define ATS_SLAVE_ADDR 7'h36
// internal conversion clock period in ns and the system clock period in ns
`define ATS_INT_CONV_PERIOD_NS 40
`define ATS_CLK_PERIOD_NS 5

`endif

/* src/ats_sequencer.v */
`timescale 1ns/1ps
`include "ats_regs.vh"

module ats_sequencer #(
    parameter [6:0] SLAVE_ADDR = `ATS_SLAVE_ADDR,
    parameter integer INT_CONV_PERIOD_NS = `ATS_INT_CONV_PERIOD_NS
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial pins, open drain
    input wire scl_i,
    output wire scl_oe,
    input wire sda_i,
    output wire sda_oe,
    // stored settings
    input wire cfg_load,
    input wire cfg_clock_ext,
    input wire input_mode_select,
    input wire channel_select,
    input wire polarity_select,
    // analog front end
    input wire comp_hi,
    output wire [9:0] dac_code,
    output wire track,
    output wire [1:0] mux_pos,
    output wire [1:0] mux_neg,
    output wire bipolar,
    // status
    output wire busy,
    output wire conv_done,
    output wire [9:0] result
);

    // internal conversion clock divider length, at least one cycle
    localparam integer DIV_RAW = INT_CONV_PERIOD_NS / `ATS_CLK_PERIOD_NS;
    localparam integer DIV_CYC = (DIV_RAW < 1) ? 1 : DIV_RAW;
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_CONV = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;
    reg [2:0] state_q;
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] addr_sh_q;
    reg [15:0] out_sh_q;
    reg match_q, byte_idx_q, nack_q, track_q;
    reg scl_oe_q, sda_oe_q;
    reg clk_ext_q, single_q, chan_q, pol_q;
    reg sar_run_q, done_q, div_tick, conv_hold_start;
    reg [3:0] sar_idx_q;
    reg [9:0] trial_q, result_q;
    reg [31:0] div_q;
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start_det = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
    wire stop_det = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;
    // conversion clock: serial clock or internal divider
    wire conv_tick = sar_run_q & (clk_ext_q ? scl_rise : div_tick);
    wire [3:0] bit_nx = bit_cnt_q + 4'h1;

    // two-flop synchronisers on both pins, third flop for edges
    always @(posedge clk) begin
        if (!rst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // stored settings
    always @(posedge clk) begin
        if (!rst_n) begin
            clk_ext_q <= 1'b0;
            single_q <= 1'b1;
            chan_q <= 1'b0;
            pol_q <= 1'b0;
        end else if (cfg_load) begin
            clk_ext_q <= cfg_clock_ext;
            single_q <= input_mode_select;
            chan_q <= channel_select;
            pol_q <= polarity_select;
        end
    end

    // internal conversion clock divider, runs only while converting
    always @(posedge clk) begin
        if (!rst_n || !sar_run_q) begin
            div_q <= 32'h0;
            div_tick <= 1'b0;
        end else if (div_q == DIV_CYC - 1) begin
            div_q <= 32'h0;
            div_tick <= 1'b1;
        end else begin
            div_q <= div_q + 32'h1;
            div_tick <= 1'b0;
        end
    end

    // successive approximation, one result bit per conversion clock
    always @(posedge clk) begin
        if (!rst_n) begin
            sar_run_q <= 1'b0;
            sar_idx_q <= 4'h0;
            trial_q <= 10'h0;
            result_q <= 10'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_det || stop_det) begin
                sar_run_q <= 1'b0;
            end else if (conv_hold_start) begin
                sar_run_q <= 1'b1;
                sar_idx_q <= `ATS_SAR_MSB;
                trial_q <= `ATS_SAR_TRIAL;
            end else if (conv_tick) begin
                if (!comp_hi) begin
                    trial_q[sar_idx_q] <= 1'b0;
                end
                if (sar_idx_q == 4'h0) begin
                    sar_run_q <= 1'b0;
                    done_q <= 1'b1;
                    result_q <= comp_hi ? trial_q : {trial_q[9:1], 1'b0};
                end else begin
                    trial_q[sar_idx_q - 4'h1] <= 1'b1;
                    sar_idx_q <= sar_idx_q - 4'h1;
                end
            end
        end
    end

    // hold entry that also starts a conversion
    always @* begin
        conv_hold_start = 1'b0;
        if (state_q == ST_ADDR && scl_fall && bit_cnt_q == `ATS_ACK_PULSE
                && match_q && !clk_ext_q) begin
            conv_hold_start = 1'b1;
        end
        if (state_q == ST_READ && scl_rise && !byte_idx_q
                && bit_nx == `ATS_HOLD_PULSE && clk_ext_q) begin
            conv_hold_start = 1'b1;
        end
    end

    // framing, track/hold sequencing and serial output
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            addr_sh_q <= 8'h0;
            match_q <= 1'b0;
            out_sh_q <= 16'h0;
            byte_idx_q <= 1'b0;
            nack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            track_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            match_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            if (conv_hold_start) begin
                track_q <= 1'b0;
            end
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_nx;
                        if (bit_nx <= `ATS_ADDR_BITS) begin
                            addr_sh_q <= {addr_sh_q[6:0], sda_s_q};
                        end
                        if (bit_nx == `ATS_ADDR_BITS && addr_sh_q[6:0] == SLAVE_ADDR
                                && sda_s_q) begin
                            match_q <= 1'b1;
                            track_q <= 1'b1;
                        end
                    end
                    if (scl_fall && bit_cnt_q == `ATS_ADDR_BITS) begin
                        sda_oe_q <= match_q; // acknowledge
                        if (!match_q) begin
                            state_q <= ST_WAIT;
                        end
                    end
                    if (scl_fall && bit_cnt_q == `ATS_ACK_PULSE) begin
                        bit_cnt_q <= 4'h0;
                        byte_idx_q <= 1'b0;
                        nack_q <= 1'b0;
                        if (!clk_ext_q) begin
                            state_q <= ST_CONV;
                            scl_oe_q <= 1'b1;
                            sda_oe_q <= 1'b0;
                        end else begin
                            state_q <= ST_READ;
                            out_sh_q <= {`ATS_PAD_ONES, result_q};
                            sda_oe_q <= 1'b0; // pad bit is a one
                        end
                    end
                end
                ST_CONV: begin
                    if (done_q) begin
                        state_q <= ST_READ;
                        scl_oe_q <= 1'b0;
                        out_sh_q <= {`ATS_PAD_ONES, result_q};
                        sda_oe_q <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_nx;
                        if (bit_nx == `ATS_ACK_PULSE) begin
                            nack_q <= sda_s_q;
                        end
                    end
                    if (scl_fall) begin
                        if (bit_cnt_q == `ATS_ACK_PULSE) begin
                            bit_cnt_q <= 4'h0;
                            if (nack_q || byte_idx_q) begin
                                state_q <= ST_WAIT;
                            end else begin
                                byte_idx_q <= 1'b1;
                                sda_oe_q <= ~out_sh_q[15];
                            end
                        end else if (bit_cnt_q == `ATS_ADDR_BITS) begin
                            out_sh_q <= {out_sh_q[14:0], 1'b1};
                            sda_oe_q <= 1'b0; // master acknowledge slot
                        end else begin
                            out_sh_q <= {out_sh_q[14:0], 1'b1};
                            sda_oe_q <= ~out_sh_q[14];
                        end
                    end
                end
                ST_WAIT: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // input routing: single-ended against ground or a differential pair
    reg [1:0] pos_d, neg_d;
    always @* begin
        if (single_q) begin
            pos_d = chan_q ? `ATS_LEG_AIN1 : `ATS_LEG_AIN0;
            neg_d = `ATS_LEG_GND;
        end else begin
            pos_d = chan_q ? `ATS_LEG_AIN1 : `ATS_LEG_AIN0;
            neg_d = chan_q ? `ATS_LEG_AIN0 : `ATS_LEG_AIN1;
        end
    end
    assign mux_pos = pos_d;
    assign mux_neg = neg_d;
    assign bipolar = pol_q & ~single_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign track = track_q;
    assign dac_code = trial_q;
    assign busy = sar_run_q;
    assign conv_done = done_q;
    assign result = result_q;

endmodule // ats_sequencer

/* verification/ats_sequencer_sva.sv */
`timescale 1ns/1ps
module ats_sequencer_sva (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial pins
    input wire scl_i,
    input wire scl_oe,
    // front end and status
    input wire track,
    input wire busy,
    input wire conv_done,
    input wire [9:0] dac_code,
    input wire [1:0] mux_pos,
    input wire [1:0] mux_neg,
    input wire bipolar
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // clock stretch opens, then closes after the internal conversion
    sequence s_stretch_start;
        $rose(scl_oe);
    endsequence
    sequence s_stretch_end;
        ##[70:100] $fell(scl_oe);
    endsequence
    property p_track_on_rise;
        $rose(track) |-> scl_i && !scl_oe;
    endproperty
    a_track_on_rise: assert property (p_track_on_rise) else $error("track rose off a high clock");
    property p_hold_at_stretch;
        s_stretch_start |-> !track && !scl_i;
    endproperty
    a_hold_at_stretch: assert property (p_hold_at_stretch) else $error("stretch without hold");
    property p_stretch_len;
        s_stretch_start |-> s_stretch_end;
    endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");
    property p_busy_in_stretch;
        s_stretch_start |-> ##[0:2] busy;
    endproperty
    a_busy_in_stretch: assert property (p_busy_in_stretch) else $error("stretch without busy");
    property p_release_on_done;
        $fell(scl_oe) |-> $past(conv_done) || $past(conv_done, 2);
    endproperty
    a_release_on_done: assert property (p_release_on_done) else $error("early release");
    property p_hold_in_conv;
        busy |-> !track;
    endproperty
    a_hold_in_conv: assert property (p_hold_in_conv) else $error("tracking while busy");
    property p_done_pulse;
        conv_done |=> !conv_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_sar_start;
        $rose(busy) |-> ##[0:2] dac_code == 10'h200;
    endproperty
    a_sar_start: assert property (p_sar_start) else $error("first trial wrong");
    property p_done_after_busy;
        conv_done |-> $past(busy);
    endproperty
    a_done_after_busy: assert property (p_done_after_busy) else $error("done without busy");
    property p_legs;
        mux_pos != 2'h2 && (mux_neg == 2'h2 || mux_neg == {1'b0, ~mux_pos[0]});
    endproperty
    a_legs: assert property (p_legs) else $error("illegal leg pair");
    property p_unipolar_se;
        mux_neg == 2'h2 |-> !bipolar;
    endproperty
    a_unipolar_se: assert property (p_unipolar_se) else $error("bipolar in single-ended");
endmodule // ats_sequencer_sva

bind ats_sequencer ats_sequencer_sva u_sva (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
    .scl_oe(scl_oe), .track(track), .busy(busy), .conv_done(conv_done), .dac_code(dac_code),
    .mux_pos(mux_pos), .mux_neg(mux_neg), .bipolar(bipolar));

/* verification/ats_master_model.sv */
`timescale 1ns/1ps
module ats_master_model #(
    parameter integer HALF = 70
) (
    // bench clock
    input wire clk,
    // resolved lines
    input wire scl_line,
    input wire sda_line,
    // open-drain pulls
    output logic scl_low,
    output logic sda_low
);
    // bus idle
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wt(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // one bit: set data while low, wait out stretch, sample mid-high
    task automatic bit_io(input logic b, output logic s);
        wt(HALF / 4);
        sda_low = ~b;
        wt(HALF);
        scl_low = 1'b0;
        // a stretch that never ends is caught by the bench watchdog
        while (scl_line !== 1'b1) begin
            wt(1);
        end
        wt(HALF / 2);
        s = sda_line;
        wt(HALF / 2);
        scl_low = 1'b1;
    endtask
    // start, address, two-byte read if a read address is acked, stop
    task automatic xfer(input logic [7:0] a, output logic ack, output logic [15:0] d);
        logic s;
        integer i;
        d = 16'h0000;
        sda_low = 1'b1;
        wt(HALF);
        scl_low = 1'b1;
        for (i = 7; i >= 0; i--) bit_io(a[i], s);
        bit_io(1'b1, ack);
        if (ack === 1'b0 && a[0]) begin
            for (i = 15; i >= 8; i--) bit_io(1'b1, d[i]);
            bit_io(1'b0, s);
            for (i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
            bit_io(1'b1, s);
        end
        wt(HALF / 4);
        sda_low = 1'b1;
        wt(HALF);
        scl_low = 1'b0;
        wt(HALF);
        sda_low = 1'b0;
        wt(HALF);
    endtask
endmodule // ats_master_model

/* verification/ats_sequencer_test.sv */
`timescale 1ns/1ps
module ats_sequencer_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_load = 1'b0;
    logic cfg_clock_ext = 1'b0;
    logic input_mode_select = 1'b1;
    logic channel_select = 1'b0;
    logic polarity_select = 1'b0;
    logic comp_hi = 1'b0;
    logic [9:0] target = 10'h000;
    logic scl_low;
    logic sda_low;
    wire scl_oe, sda_oe, track, bipolar, busy, conv_done;
    wire [9:0] dac_code;
    wire [9:0] result;
    wire [1:0] mux_pos;
    wire [1:0] mux_neg;
    wire scl_line = ~(scl_low | scl_oe);
    wire sda_line = ~(sda_low | sda_oe);
    integer failures = 0;
    integer checks = 0;
    always #2.5 clk = ~clk;
    // comparator against the held input
    always @(negedge clk) comp_hi <= (target >= dac_code);
    ats_sequencer #(.SLAVE_ADDR(7'h36)) DUT (.clk(clk), .rst_n(rst_n), .scl_i(scl_line),
        .scl_oe(scl_oe), .sda_i(sda_line), .sda_oe(sda_oe), .cfg_load(cfg_load),
        .cfg_clock_ext(cfg_clock_ext), .input_mode_select(input_mode_select),
        .channel_select(channel_select), .polarity_select(polarity_select), .comp_hi(comp_hi),
        .dac_code(dac_code), .track(track), .mux_pos(mux_pos), .mux_neg(mux_neg),
        .bipolar(bipolar), .busy(busy), .conv_done(conv_done), .result(result));
    ats_master_model m (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
        .scl_low(scl_low), .sda_low(sda_low));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cfg(input logic ext, input logic se, input logic ch, input logic pol);
        @(negedge clk);
        cfg_clock_ext = ext;
        input_mode_select = se;
        channel_select = ch;
        polarity_select = pol;
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
        @(negedge clk);
    endtask
    // every mode, channel and polarity combination
    task automatic t_routing;
        integer k;
        logic [1:0] p;
        logic [1:0] n;
        for (k = 0; k < 8; k++) begin
            cfg(1'b0, k[0], k[1], k[2]);
            p = {1'b0, k[1]};
            n = k[0] ? 2'h2 : {1'b0, ~p[0]};
            chk("mux_pos", {14'h0, mux_pos}, {14'h0, p});
            chk("mux_neg", {14'h0, mux_neg}, {14'h0, n});
            chk("bipolar", {15'h0, bipolar}, {15'h0, k[2] & ~k[0]});
        end
        $display("test routing done");
    endtask
    // read; external mode shows the previous result
    task automatic t_read(input logic ext, input logic [9:0] tgt, input logic [9:0] shown);
        logic ack;
        logic [15:0] d;
        cfg(ext, 1'b1, 1'b0, 1'b0);
        target = tgt;
        m.xfer(8'h6D, ack, d);
        chk("addr_ack", {15'h0, ack}, 16'h0000);
        chk("read_data", d, {6'h3F, shown});
        chk("result", {6'h0, result}, {6'h0, tgt});
        $display("test read done");
    endtask
    // write address is not answered and starts nothing
    task automatic t_refused;
        logic ack;
        logic [15:0] d;
        m.xfer(8'h6C, ack, d);
        chk("write_ack", {15'h0, ack}, 16'h0001);
        chk("track", {14'h0, track, busy}, 16'h0000);
        $display("test refused done");
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_routing;
        t_read(1'b0, 10'h000, 10'h000);
        t_read(1'b0, 10'h3FF, 10'h3FF);
        t_read(1'b0, 10'h2A5, 10'h2A5);
        t_refused;
        t_read(1'b1, 10'h15A, 10'h2A5);
        t_read(1'b1, 10'h0C3, 10'h15A);
        end_sim;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule // ats_sequencer_test
